// ===== rtl/bmbc_top.sv
// Control logic of a single H-bridge brushed DC motor driver.
// Behaviour
// [R1] Inputs select forward, reverse or brake drive.
// [R2] Both inputs low opens bridge, then standby.
// [R3] Standby entry after 0.7 to 1.5 ms.
// [R4] Host keeps inputs steady in transition window.
// [R5] Host keeps plain stop under 0.7 ms.
// [R6] Host holds stop 1.5 ms for standby.
// [R7] Either input high leaves standby.
// [R8] Outputs follow inputs within 30 us.
// [R9] Comparator blanked 3.6 us after decay-to-charge.
// [R10] 400 ns filter on threshold crossings.
// [R11] Input transitions also restart spike blanking.
// [R12] Fixed off-time, half fast, half slow.
// [R13] Zero current in fast decay opens bridge.
// [R14] Reference direction switch pattern per phase.
// [R15] Dead time at every switch transition.
// [R16] Trip level is reference over ten.
// [R17] Host toggles inputs no faster than 400 kHz.
// [R18] Reverse direction uses mirrored switch pattern.
// [R19] Chop: charge, trip, fixed decay, charge.
`timescale 1ns/1ps
module bmbc_top
	import bmbc_pkg::*;
#(
	parameter int STBY_CYCLES = bmbc_pkg::STBY_CYC, // Stop cycles before standby.
	parameter int TOFF_CYCLES = bmbc_pkg::TOFF_CYC, // Fixed decay off-time cycles.
	parameter int AW = bmbc_pkg::ADC_W // Reference and sense word width.
) (
	input wire logic ref_clk, // System clock, 50 MHz.
	input wire logic rst, // Synchronous reset, active high.
	input wire logic clk_en, // Clock enable; freezes state when low.
	input wire logic input_a, // Logic input a from the host pin.
	input wire logic input_b, // Logic input b from the host pin.
	input wire logic [AW-1:0] current_reference, // Digitised reference level.
	input wire logic [AW-1:0] sense_resistor_node, // Digitised sense voltage.
	input wire logic current_zero, // Zero-current detector from the bridge.
	input wire logic chop_enable, // High enables constant-current chopping.
	output logic high_side_a, // High-side switch of leg a.
	output logic high_side_b, // High-side switch of leg b.
	output logic low_side_a, // Low-side switch of leg a.
	output logic low_side_b, // Low-side switch of leg b.
	output logic bridge_out_a, // Logical level of output a when driven.
	output logic bridge_out_b, // Logical level of output b when driven.
	output logic bridge_oe_a, // Output a is driven when high.
	output logic bridge_oe_b, // Output b is driven when high.
	output logic standby // High while in low-power standby.
);
	import bmbc_pkg::*;

	// Two-stage synchronisers for the asynchronous pins.
	logic [1:0] sync_a;
	logic [1:0] sync_b;
	logic [1:0] sync_z;
	logic [1:0] sync_c;
	// Synchronised input levels and their previous values.
	logic in_a;
	logic in_b;
	logic prev_a;
	logic prev_b;
	logic zero_seen;
	// Chop enable after its synchroniser; the pin may change at any time.
	logic chop_on;
	// Mode state and its counters.
	bmbc_mode_type mode;
	bmbc_mode_type next_mode;
	logic [31:0] stop_cnt;
	logic [15:0] wake_cnt;
	// Chopper state.
	bmbc_phase_type phase;
	bmbc_phase_type next_phase;
	logic [31:0] toff_cnt;
	logic [15:0] blank_cnt;
	logic [15:0] filt_cnt;
	// Requested switch states before dead time.
	logic want_ha;
	logic want_hb;
	logic want_la;
	logic want_lb;

	// Synchronise the pins; logic reads only the second stage of each pair.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sync_a <= 2'h0;
			sync_b <= 2'h0;
			sync_z <= 2'h0;
			sync_c <= 2'h0;
		end else if (clk_en) begin
			sync_a <= {sync_a[0], input_a};
			sync_b <= {sync_b[0], input_b};
			sync_z <= {sync_z[0], current_zero};
			sync_c <= {sync_c[0], chop_enable};
		end
	end
	assign in_a = sync_a[1];
	assign in_b = sync_b[1];
	assign zero_seen = sync_z[1];
	// Chop enable is a pin as well, so a change takes effect two cycles late.
	assign chop_on = sync_c[1];

	// Decoded input states.
	wire both_low = !in_a && !in_b;
	wire drive_fwd = in_a && !in_b;
	wire drive_rev = !in_a && in_b;
	wire drive_brake = in_a && in_b;
	wire in_edge = (in_a != prev_a) || (in_b != prev_b);

	// Mode sequencing: stop timer, standby, wake delay.
	wire stop_expired = stop_cnt >= 32'(STBY_CYCLES - 1);
	// Waking is cut short by a margin of four dead times, covering the synchroniser and one dead time,
	// so the bridge is driving before the release limit runs out, not after it.
	wire wake_done = wake_cnt >= 16'(WAKE_CYC - 4 * DEAD_CYC - 1); // [R8]
	always_comb begin
		next_mode = mode;
		case (mode)
			BMBC_RUN: begin
				if (both_low) begin
					next_mode = BMBC_STOPPING; // [R2]
				end
			end
			BMBC_STOPPING: begin
				if (!both_low) begin
					next_mode = BMBC_RUN;
				end else if (stop_expired) begin
					next_mode = BMBC_STANDBY; // [R3]
				end
			end
			BMBC_STANDBY: begin
				if (!both_low) begin
					next_mode = BMBC_WAKING; // [R7]
				end
			end
			BMBC_WAKING: begin
				if (wake_done) begin
					next_mode = BMBC_RUN; // [R8]
				end
			end
			default: next_mode = BMBC_RUN;
		endcase
	end

	// Mode register and its timers.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			mode <= BMBC_RUN;
			stop_cnt <= 32'h0;
			wake_cnt <= 16'h0;
			prev_a <= 1'b0;
			prev_b <= 1'b0;
		end else if (clk_en) begin
			mode <= next_mode;
			prev_a <= in_a;
			prev_b <= in_b;
			// The stop timer runs only while in the stopping mode.
			stop_cnt <= (mode == BMBC_STOPPING) ? stop_cnt + 32'h1 : 32'h0; // [R3]
			wake_cnt <= (mode == BMBC_WAKING) ? wake_cnt + 16'h1 : 16'h0; // [R8]
		end
	end
	assign standby = (mode == BMBC_STANDBY);

	// Trip level is the reference over ten; compare sense times ten against it to avoid a divider.
	wire [AW+3:0] sense_x10 = (AW + 4)'(sense_resistor_node) * (AW + 4)'(REF_DIV);
	wire raw_trip = sense_x10 >= (AW + 4)'(current_reference); // [R16]
	// The comparator is valid only once both blanking and filter windows pass.
	wire blanked = blank_cnt < 16'(BLANK_CYC); // [R9]
	wire trip_valid = !blanked && (filt_cnt >= 16'(FILT_CYC - 1)) && raw_trip; // [R10]
	wire driving = (mode == BMBC_RUN) && (drive_fwd || drive_rev);
	wire half_toff = toff_cnt >= 32'(TOFF_CYCLES / 2 - 1);
	wire full_toff = toff_cnt >= 32'(TOFF_CYCLES - 1);

	// Chopper phase sequence.
	always_comb begin
		next_phase = phase;
		case (phase)
			BMBC_CHARGE: begin
				if (chop_on && trip_valid) begin
					next_phase = BMBC_FAST; // [R19]
				end
			end
			BMBC_FAST: begin
				if (zero_seen) begin
					next_phase = BMBC_OPEN; // [R13]
				end else if (half_toff) begin
					next_phase = BMBC_SLOW; // [R12]
				end
			end
			BMBC_SLOW, BMBC_OPEN: begin
				if (full_toff) begin
					next_phase = BMBC_CHARGE; // [R19]
				end
			end
			default: next_phase = BMBC_CHARGE;
		endcase
		if (!driving) begin
			next_phase = BMBC_CHARGE;
		end
	end

	// Chopper registers: phase, off-time, blanking and filter counters.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			phase <= BMBC_CHARGE;
			toff_cnt <= 32'h0;
			blank_cnt <= 16'h0;
			filt_cnt <= 16'h0;
		end else if (clk_en) begin
			phase <= next_phase;
			toff_cnt <= (phase != BMBC_CHARGE) ? toff_cnt + 32'h1 : 32'h0; // [R12]
			// Blanking restarts on decay-to-charge and on every input edge.
			if ((phase != BMBC_CHARGE && next_phase == BMBC_CHARGE) || in_edge) begin
				blank_cnt <= 16'h0; // [R9] [R11]
			end else if (blanked) begin
				blank_cnt <= blank_cnt + 16'h1;
			end
			// The filter needs the raw trip to hold for its full width.
			if (!raw_trip) begin
				filt_cnt <= 16'h0; // [R10]
			end else if (filt_cnt < 16'(FILT_CYC - 1)) begin
				filt_cnt <= filt_cnt + 16'h1;
			end
		end
	end

	// Switch requests per mode and phase; reverse mirrors the legs.
	wire ph_charge = phase == BMBC_CHARGE;
	wire ph_fast = phase == BMBC_FAST;
	wire ph_slow = phase == BMBC_SLOW;
	wire run = mode == BMBC_RUN;
	assign want_ha = run && ((drive_fwd && ph_charge) || (drive_rev && ph_fast)); // [R1] [R14] [R18]
	assign want_hb = run && ((drive_rev && ph_charge) || (drive_fwd && ph_fast)); // [R1] [R14] [R18]
	assign want_la = run && (drive_brake || ((drive_fwd || drive_rev) && ph_slow)
		|| (drive_fwd && ph_fast) || (drive_rev && ph_charge)); // [R14] [R18]
	assign want_lb = run && (drive_brake || ((drive_fwd || drive_rev) && ph_slow)
		|| (drive_rev && ph_fast) || (drive_fwd && ph_charge)); // [R14] [R18]

	// Dead time per leg.
	bmbc_leg #(.DEAD(DEAD_CYC)) u_leg_a (
		.ref_clk(ref_clk),
		.rst(rst),
		.clk_en(clk_en),
		.want_high(want_ha),
		.want_low(want_la),
		.high_on(high_side_a),
		.low_on(low_side_a)
	);
	bmbc_leg #(.DEAD(DEAD_CYC)) u_leg_b (
		.ref_clk(ref_clk),
		.rst(rst),
		.clk_en(clk_en),
		.want_high(want_hb),
		.want_low(want_lb),
		.high_on(high_side_b),
		.low_on(low_side_b)
	);

	// Pin view of the bridge: a node is driven when either switch of its leg conducts.
	assign bridge_out_a = high_side_a;
	assign bridge_out_b = high_side_b;
	assign bridge_oe_a = high_side_a || low_side_a; // [R2]
	assign bridge_oe_b = high_side_b || low_side_b; // [R2]

	// Standby is reached exactly after the configured stop time.
	a_stby_entry: assert property (@(posedge ref_clk) disable iff (rst) // [R3]
		$rose(standby) |-> $past(stop_cnt) == 32'(STBY_CYCLES - 1)) else $error("Standby entry time wrong.");
	// An input going high in standby leaves it on the next cycle.
	a_stby_exit: assert property (@(posedge ref_clk) disable iff (rst) // [R7]
		(standby && !both_low && clk_en) |=> !standby) else $error("Standby not released.");
	// Waking ends within the wake limit.
	a_wake_bound: assert property (@(posedge ref_clk) disable iff (rst) // [R8]
		(mode == BMBC_WAKING) |-> wake_cnt < 16'(WAKE_CYC)) else $error("Wake took too long.");
	// While waking, the bridge stays open; drive only resumes in run mode.
	a_wake_off: assert property (@(posedge ref_clk) disable iff (rst) // [R8]
		(mode == BMBC_WAKING) |-> !bridge_oe_a && !bridge_oe_b) else $error("Bridge driven while waking.");
	// Stop opens both outputs within a few cycles.
	a_stop_open: assert property (@(posedge ref_clk) disable iff (rst || !clk_en) // [R2]
		(both_low && $past(both_low, 1) && $past(both_low, 2)) |-> !bridge_oe_a && !bridge_oe_b)
		else $error("Bridge not open in stop.");
	// No trip may start decay during blanking.
	a_blank_hold: assert property (@(posedge ref_clk) disable iff (rst) // [R9]
		(ph_charge && blanked) |=> !ph_fast) else $error("Trip taken during blanking.");
	// Fast decay lasts half the off-time unless zero current opens the bridge.
	a_fast_half: assert property (@(posedge ref_clk) disable iff (rst) // [R12]
		(ph_slow && !$past(ph_slow) && clk_en) |-> $past(toff_cnt) == 32'(TOFF_CYCLES / 2 - 1))
		else $error("Fast decay length wrong.");
	// Zero current in fast decay moves to open phase.
	a_zero_open: assert property (@(posedge ref_clk) disable iff (rst)
		(ph_fast && zero_seen && driving && clk_en) |=> phase == BMBC_OPEN) else $error("Zero not acted on."); // [R13]
	// Charge ends only on a filtered trip above reference over ten.
	a_trip_cause: assert property (@(posedge ref_clk) disable iff (rst) // [R10] [R16]
		(ph_charge ##1 ph_fast) |-> $past(raw_trip) && $past(filt_cnt) >= 16'(FILT_CYC - 1))
		else $error("Decay without valid trip.");
	// Once the open phase has lasted a cycle, both bridge nodes float.
	a_open_hiz: assert property (@(posedge ref_clk) disable iff (rst) // [R13]
		(phase == BMBC_OPEN && $past(phase == BMBC_OPEN)) |-> !bridge_oe_a && !bridge_oe_b)
		else $error("Bridge not open after zero current.");
	// Brake drive request pattern.
	a_brake_low: assert property (@(posedge ref_clk) disable iff (rst)
		(run && drive_brake) |-> want_la && want_lb && !want_ha && !want_hb) else $error("Brake pattern wrong."); // [R1]

	c_standby: cover property (@(posedge ref_clk) $rose(standby));
	c_wake: cover property (@(posedge ref_clk) (mode == BMBC_WAKING) ##1 run);
	c_chop: cover property (@(posedge ref_clk) ph_fast ##1 ph_slow);
	c_zero: cover property (@(posedge ref_clk) phase == BMBC_OPEN);
	// An input edge while chopping restarts the spike blanking.
	c_edge_blank: cover property (@(posedge ref_clk) in_edge && run && chop_on);
endmodule

// ===== rtl/bmbc_pkg.sv
// Package of timing constants and mode encodings for the brushed motor bridge control block.
package bmbc_pkg;
	// Clock rate in kHz, 50 MHz reference clock.
	localparam int CLK_KHZ = 50000;
	// Standby entry time window in microseconds, nominal 1 ms.
	localparam int STBY_MIN_US = 700;
	localparam int STBY_NOM_US = 1000;
	localparam int STBY_MAX_US = 1500;
	// Cycles of continuous stop before standby, nominal value used.
	localparam int STBY_CYC = STBY_NOM_US * CLK_KHZ / 1000;
	// Standby release wake time in microseconds, a longest time.
	localparam int WAKE_US = 30;
	localparam int WAKE_CYC = WAKE_US * CLK_KHZ / 1000;
	// Spike blanking time in nanoseconds.
	localparam int BLANK_NS = 3600;
	localparam int BLANK_CYC = (BLANK_NS * CLK_KHZ / 1000 + 999) / 1000;
	// Threshold filter time in nanoseconds.
	localparam int FILT_NS = 400;
	localparam int FILT_CYC = (FILT_NS * CLK_KHZ / 1000 + 999) / 1000;
	// Dead time window in nanoseconds; the least time is used.
	localparam int DEAD_MIN_NS = 200;
	localparam int DEAD_MAX_NS = 300;
	localparam int DEAD_CYC = (DEAD_MIN_NS * CLK_KHZ / 1000 + 999) / 1000;
	// Default fixed decay off-time in nanoseconds.
	localparam int TOFF_NS = 20000;
	localparam int TOFF_CYC = TOFF_NS * CLK_KHZ / 1000000;
	// Reference attenuation divisor for the trip level.
	localparam int REF_DIV = 10;
	// Width of the digitised reference and sense words.
	localparam int ADC_W = 12;
	// Chopper phases.
	typedef enum logic [1:0] {
		BMBC_CHARGE = 2'b00,
		BMBC_FAST = 2'b01,
		BMBC_SLOW = 2'b10,
		BMBC_OPEN = 2'b11
	} bmbc_phase_type;
	// Operating modes.
	typedef enum logic [1:0] {
		BMBC_RUN = 2'b00,
		BMBC_STOPPING = 2'b01,
		BMBC_STANDBY = 2'b10,
		BMBC_WAKING = 2'b11
	} bmbc_mode_type;
endpackage

// ===== rtl/bmbc_leg.sv
// Dead time inserter for one half bridge leg.
`timescale 1ns/1ps
module bmbc_leg #(
	parameter int DEAD = 10 // Dead time in clock cycles.
) (
	input wire logic ref_clk, // System clock.
	input wire logic rst, // Synchronous reset, active high.
	input wire logic clk_en, // Clock enable.
	input wire logic want_high, // Requested high-side switch state.
	input wire logic want_low, // Requested low-side switch state.
	output logic high_on, // Gated high-side switch drive.
	output logic low_on // Gated low-side switch drive.
);
	// Counter of cycles since the request last changed.
	logic [7:0] dead_cnt;
	// Last request, used to spot changes.
	logic last_high;
	logic last_low;
	// A change of request restarts the off window for the whole leg.
	wire req_change = (want_high != last_high) || (want_low != last_low);
	wire dead_done = (dead_cnt >= 8'(DEAD)) && !req_change;

	// Track the request and time the off window.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			dead_cnt <= 8'h00;
			last_high <= 1'b0;
			last_low <= 1'b0;
			high_on <= 1'b0;
			low_on <= 1'b0;
		end else if (clk_en) begin
			last_high <= want_high;
			last_low <= want_low;
			if (req_change) begin
				dead_cnt <= 8'h00;
			end else if (!dead_done) begin
				dead_cnt <= dead_cnt + 8'h01;
			end
			// Both switches stay off until the window expires, so no shoot-through.
			high_on <= dead_done && want_high && !want_low; // [R15]
			low_on <= dead_done && want_low && !want_high; // [R15]
		end
	end

	// The two switches of a leg are never on together.
	a_leg_exclusive: assert property (@(posedge ref_clk) disable iff (rst) // [R15]
		!(high_on && low_on)) else $error("Both switches of a leg are on.");
	// The high side turning on was preceded by the low side being off two and three cycles before.
	a_leg_dead: assert property (@(posedge ref_clk) disable iff (rst) // [R15]
		$rose(high_on) |-> $past(!low_on, 2) && $past(!low_on, 3)) else $error("High side on without dead time.");
endmodule

// ===== bench/bmbc_host.sv
// Behavioural model of the host controller that drives the two logic inputs.
`timescale 1ns/1ps
module bmbc_host #(
	parameter int MIN_GAP = 63, // Least cycles between two input changes.
	parameter int WIN_LO = 140, // Start of the standby transition window in cycles.
	parameter int WIN_HI = 300 // End of the standby transition window in cycles.
) (
	input wire logic ref_clk, // System clock.
	input wire logic rst, // Synchronous reset, active high.
	input wire logic req_a, // Requested level of input a.
	input wire logic req_b, // Requested level of input b.
	output logic input_a, // Logic input a to the device.
	output logic input_b // Logic input b to the device.
);
	int gap; // Cycles since the last applied change.
	int stop_len; // Cycles spent with both inputs low.
	// A request differs from what is on the pins.
	wire logic changing = (req_a != input_a) || (req_b != input_b);
	// Both pins are low, so the device is heading for standby.
	wire logic in_stop = !input_a && !input_b;
	// Inside the window the device state is undefined, so a change waits until it has passed.
	wire logic win_block = in_stop && (stop_len >= WIN_LO) && (stop_len < WIN_HI);
	// Apply a pending request once spacing and window allow it.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			input_a <= 1'b0;
			input_b <= 1'b0;
			gap <= MIN_GAP;
			stop_len <= 0;
		end else begin
			gap <= (gap < MIN_GAP) ? gap + 1 : gap;
			stop_len <= in_stop ? stop_len + 1 : 0;
			// Half a 400 kHz period is the fastest toggle the host allows itself.
			if (changing && (gap >= MIN_GAP) && !win_block) begin
				input_a <= req_a;
				input_b <= req_b;
				gap <= 0;
			end
		end
	end
endmodule

// ===== bench/test_brushed_motor_bridge_control.sv
// Self-checking testbench of the brushed motor bridge control block.
`timescale 1ns/1ps
module test_brushed_motor_bridge_control;
	import bmbc_pkg::*;
	// Output words as {standby, oe a, oe b, out a, out b, hs a, hs b, ls a, ls b}.
	localparam logic [8:0] FWD = 9'h0e9;
	localparam logic [8:0] REV = 9'h0d6;
	localparam logic [8:0] BRK = 9'h0c3;
	localparam logic [8:0] OFF = 9'h000;
	localparam logic [8:0] STB = 9'h100;
	logic ref_clk, rst, clk_en, req_a, req_b, current_zero, chop_enable, chk_req;
	logic input_a, input_b, high_side_a, high_side_b, low_side_a, low_side_b;
	logic bridge_out_a, bridge_out_b, bridge_oe_a, bridge_oe_b, standby;
	logic [11:0] current_reference, sense_resistor_node, ref_lvl;
	logic [31:0] lfsr;
	logic [8:0] q[$]; // Expected output words, oldest first.
	int miscompares, n_checks, cycles, n, nf, ns;
	// Observed output word, in the same order as the expectations.
	wire logic [8:0] obs = {standby, bridge_oe_a, bridge_oe_b, bridge_out_a, bridge_out_b,
		high_side_a, high_side_b, low_side_a, low_side_b};
	// Shortened standby and off-time counts keep the run brief.
	bmbc_top #(.STBY_CYCLES(200), .TOFF_CYCLES(40), .AW(ADC_W)) bmbc_top_inst (.ref_clk(ref_clk), .rst(rst),
		.clk_en(clk_en), .input_a(input_a), .input_b(input_b), .current_reference(current_reference),
		.sense_resistor_node(sense_resistor_node), .current_zero(current_zero), .chop_enable(chop_enable),
		.high_side_a(high_side_a), .high_side_b(high_side_b), .low_side_a(low_side_a), .low_side_b(low_side_b),
		.bridge_out_a(bridge_out_a), .bridge_out_b(bridge_out_b), .bridge_oe_a(bridge_oe_a),
		.bridge_oe_b(bridge_oe_b), .standby(standby));
	// Window bounds are 0.7 and 1.5 times the shortened standby count.
	bmbc_host #(.MIN_GAP(63), .WIN_LO(140), .WIN_HI(300)) bmbc_host_inst (.ref_clk(ref_clk), .rst(rst),
		.req_a(req_a), .req_b(req_b), .input_a(input_a), .input_b(input_b));
	// Next state of the shift register that supplies random reference levels.
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Compare one observed value with its expectation.
	task automatic check(input logic [8:0] seen, input logic [8:0] expv);
		n_checks++;
		if (seen !== expv) begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, expv);
		end
	endtask
	// Print the counts and the verdict, then stop.
	task automatic print_verdict();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Queue an expectation; the extra edge keeps the strobe from being set twice in one step.
	task automatic note(input logic [8:0] v);
		q.push_back(v);
		chk_req <= 1'b1;
		@(posedge ref_clk);
		chk_req <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge ref_clk);
	endtask
	// Wait a bounded time for a pattern, then queue it; a timeout shows as a mismatch.
	task automatic wait_vec(input logic [8:0] v, input int lim);
		int i;
		for (i = 0; i < lim && obs !== v; i++) @(posedge ref_clk);
		note(v);
	endtask
	// Hand a request to the host and wait until it reaches the pins.
	task automatic host_set(input logic a, input logic b);
		int i;
		req_a <= a;
		req_b <= b;
		for (i = 0; i < 400 && (input_a !== a || input_b !== b); i++) @(posedge ref_clk);
	endtask
	// The clock toggles every half period of 10 ns.
	initial ref_clk = 1'b0;
	always #10 ref_clk = ~ref_clk;
	// Monitor: each strobe takes the oldest expectation and compares it.
	always @(posedge ref_clk) begin
		if (chk_req === 1'b1 && q.size() > 0) begin
			check(obs, q.pop_front());
		end
	end
	// A hang is cut short well above the expected run length.
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles >= 20000) begin
			miscompares++;
			print_verdict();
		end
	end
	// Main sequence.
	initial begin
		rst = 1'b1;
		clk_en = 1'b1;
		req_a = 1'b0;
		req_b = 1'b0;
		current_reference = 12'h000;
		sense_resistor_node = 12'h000;
		current_zero = 1'b0;
		chop_enable = 1'b0;
		chk_req = 1'b0;
		miscompares = 0;
		n_checks = 0;
		cycles = 0;
		lfsr = 32'hd62b;
		cyc(2);
		rst <= 1'b0;
		note(OFF);
		// Direct drive patterns, with the dead time seen mid-reversal.
		host_set(1'b1, 1'b0);
		wait_vec(FWD, 30);
		host_set(1'b0, 1'b1);
		cyc(8);
		note(OFF);
		wait_vec(REV, 30);
		host_set(1'b1, 1'b1);
		wait_vec(BRK, 30);
		// A short stop opens the bridge without reaching standby.
		host_set(1'b0, 1'b0);
		cyc(30);
		note(OFF);
		host_set(1'b1, 1'b0);
		wait_vec(FWD, 30);
		// A long stop enters standby only after the count.
		host_set(1'b0, 1'b0);
		cyc(150);
		note(OFF);
		cyc(80);
		note(STB);
		host_set(1'b1, 1'b0);
		cyc(4);
		note(OFF);
		// The bridge must drive again within 30 us, 1500 cycles, of the pin release.
		cyc(1490);
		note(FWD);
		// Chopping with a random reference; just below the trip level nothing happens.
		lfsr = lfsr_next(lfsr);
		ref_lvl = 12'h014 + 12'(lfsr % 32'hbb8);
		current_reference <= ref_lvl;
		sense_resistor_node <= (ref_lvl - 12'h001) / 12'h00a;
		chop_enable <= 1'b1;
		cyc(400);
		note(FWD);
		sense_resistor_node <= (ref_lvl + 12'h009) / 12'h00a;
		for (n = 0; n < 80 && obs !== REV; n++) @(posedge ref_clk);
		check(obs, REV);
		for (nf = 0; nf < 80 && obs !== BRK; nf++) @(posedge ref_clk);
		for (ns = 0; ns < 80 && obs !== FWD; ns++) @(posedge ref_clk);
		check({8'h00, nf == ns}, 9'h001);
		check({8'h00, ns > 17 && ns < 23}, 9'h001);
		// The comparator is blanked after decay returns to charge.
		cyc(140);
		note(FWD);
		for (n = 0; n < 150 && obs !== REV; n++) @(posedge ref_clk);
		current_zero <= 1'b1;
		wait_vec(OFF, 20);
		current_zero <= 1'b0;
		wait_vec(FWD, 80);
		// An input edge restarts the blanking too: no decay may follow the change early.
		host_set(1'b1, 1'b1);
		wait_vec(BRK, 40);
		host_set(1'b1, 1'b0);
		cyc(20);
		note(FWD);
		cyc(120);
		note(FWD);
		wait_vec(REV, 80);
		print_verdict();
	end
endmodule
